// File: sarsr_defs.vh
`ifndef SARSR_DEFS_VH
`define SARSR_DEFS_VH

// ==========================================================
// result word layout
`define SARSR_RES_W 18
`define SARSR_RES_MSB 17
`define SARSR_BITCNT_W 5
`define SARSR_FIFO_DEPTH 4
`define SARSR_FIFO_AW 2

// ==========================================================
// core clock period, all times in picoseconds
`define SARSR_CLK_PS 5000

// conversion time, longest
`define SARSR_T_CONV_PS 710000
// strobe high pulse, far side keeps it
`define SARSR_T_WH_CNV_PS 10000
// strobe low pulse in 4-wire use, far side keeps it
`define SARSR_T_WL_CNV_PS 20000
// shift clock fall to current data invalid, least
`define SARSR_T_H_CKDO_PS 3000
// shift clock fall to next data valid, longest
`define SARSR_T_D_CKDO_PS 13400
// select low to msb valid, longest
`define SARSR_T_D_CSDO_PS 12300
// select high or last fall to release, longest
`define SARSR_T_D_DOHZ_PS 13200

// ==========================================================
// derived cycle counts: least rounds up, longest rounds down
`define SARSR_HOLD_CYC ((`SARSR_T_H_CKDO_PS + `SARSR_CLK_PS - 1) / `SARSR_CLK_PS)
`define SARSR_CKDO_CYC (`SARSR_T_D_CKDO_PS / `SARSR_CLK_PS)
`define SARSR_CSDO_CYC (`SARSR_T_D_CSDO_PS / `SARSR_CLK_PS)
`define SARSR_DOHZ_CYC (`SARSR_T_D_DOHZ_PS / `SARSR_CLK_PS)
`define SARSR_CONV_CYC (`SARSR_T_CONV_PS / `SARSR_CLK_PS)
`define SARSR_CNT_W 8

`endif

// File: sarsr_fifo.v
`timescale 1ns/100ps

module sarsr_fifo #(
	parameter integer WIDTH = 18,
	parameter integer DEPTH = 4,
	parameter integer AW = 2
) (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// filling side
	input wire in_valid,
	input wire [WIDTH-1:0] in_data,
	output wire in_ready,
	// draining side
	output wire out_valid,
	output wire [WIDTH-1:0] out_data,
	input wire out_ready
);

	// ==========================================================
	// storage and pointers
	localparam integer LAST_I = DEPTH - 1;
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];
	localparam [AW-1:0] LAST_PTR = LAST_I[AW-1:0];

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] cnt_r;
	reg [AW:0] cnt_nxt;
	reg in_ready_r;
	wire push;
	wire pop;

	assign push = in_valid & in_ready_r;
	assign pop = out_ready & (cnt_r != {(AW+1){1'b0}});
	assign in_ready = in_ready_r;
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_r];

	// occupancy after this cycle's push and pop
	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop & ~push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// ready is registered so the source sees a clean level
	always @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			in_ready_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			in_ready_r <= (cnt_nxt != FULL_CNT);
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
			end
		end
	end

	// data array needs no reset
	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

endmodule // sarsr_fifo

// File: sarsr_readout.v
`timescale 1ns/100ps
`include "sarsr_defs.vh"

module sarsr_readout (
	// clock and reset
	input wire core_clk,
	input wire sys_rst,
	// link pins, asynchronous to core_clk
	input wire conversion_strobe,
	input wire sdi,
	input wire sclk,
	// serial output pin, enable low while driving
	output wire sdo_o,
	output wire sdo_oe_n,
	// result words from the converter core
	input wire res_valid,
	input wire [`SARSR_RES_W-1:0] res_data,
	output wire res_ready,
	// status
	output wire busy,
	output wire daisy_mode,
	output wire underrun
);

	// ==========================================================
	// constants
	// integer forms first, then cut on purpose to the width of the
	// counters that they are compared with or loaded into
	localparam integer RES_BITS_I = `SARSR_RES_W;
	localparam integer CONV_LAST_I = `SARSR_CONV_CYC - 1;
	localparam integer HOLD_CYC_I = `SARSR_HOLD_CYC;
	localparam [`SARSR_BITCNT_W-1:0] RES_BITS = RES_BITS_I[`SARSR_BITCNT_W-1:0];
	localparam [`SARSR_CNT_W-1:0] CONV_LAST = CONV_LAST_I[`SARSR_CNT_W-1:0];
	localparam [1:0] HOLD_CYC = HOLD_CYC_I[1:0];

	// readout states; the unused code falls back to idle
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_CONV = 2'h1;
	localparam [1:0] ST_READ = 2'h2;

	// ==========================================================
	// declarations
	// synchroniser stages, the third only delays for edge finding
	reg cnv_m_r;
	reg cnv_s_r;
	reg cnv_d_r;
	reg sdi_m_r;
	reg sdi_s_r;
	reg sck_m_r;
	reg sck_s_r;
	reg sck_d_r;

	// sequencing and mode
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [`SARSR_CNT_W-1:0] conv_cnt_r;
	reg daisy_r;

	// shifting
	reg [`SARSR_RES_W-1:0] shreg_r;
	reg [`SARSR_BITCNT_W-1:0] bits_left_r;
	reg din_cap_r;
	reg [1:0] hold_cnt_r;
	reg shift_pend_r;

	// pin and status flops
	reg sdo_r;
	reg sdo_nxt;
	reg oe_n_r;
	reg oe_n_nxt;
	reg busy_r;
	reg underrun_r;

	// nets between the sections
	wire cnv_rise;
	wire sck_fall;
	wire fifo_valid;
	wire [`SARSR_RES_W-1:0] fifo_data;
	wire load;
	wire cs_sel;
	wire drive;
	wire shift_go;

	// ==========================================================
	// pin synchronisers
	// two flops each; the second stage feeds the logic, the third delay only the edge detect
	// reset levels equal the idle pins, so no false edge follows reset
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cnv_m_r <= 1'b1;
			cnv_s_r <= 1'b1;
			cnv_d_r <= 1'b1;
			sdi_m_r <= 1'b1;
			sdi_s_r <= 1'b1;
			sck_m_r <= 1'b0;
			sck_s_r <= 1'b0;
			sck_d_r <= 1'b0;
		end else begin
			cnv_m_r <= conversion_strobe;
			cnv_s_r <= cnv_m_r;
			cnv_d_r <= cnv_s_r;
			sdi_m_r <= sdi;
			sdi_s_r <= sdi_m_r;
			sck_m_r <= sclk;
			sck_s_r <= sck_m_r;
			sck_d_r <= sck_s_r;
		end
	end

	// edge detect on the settled copies
	// the third stage costs one cycle more but keeps the sync chain clean
	assign cnv_rise = cnv_s_r & ~cnv_d_r;
	assign sck_fall = ~sck_s_r & sck_d_r;

	// ==========================================================
	// result buffer
	// the core may run ahead by up to four results; res_ready falls when full
	// a word offered while res_ready is low simply waits at the core
	sarsr_fifo #(
		.WIDTH(`SARSR_RES_W),
		.DEPTH(`SARSR_FIFO_DEPTH),
		.AW(`SARSR_FIFO_AW)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(res_valid),
		.in_data(res_data),
		.in_ready(res_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(load)
	);

	// ==========================================================
	// conversion sequencing
	// a word is taken from the buffer when the conversion time ends
	// limitation: the timer always runs the longest conversion time, so a
	// faster core result is not passed on any earlier
	assign load = (state_r == ST_CONV) && (conv_cnt_r == CONV_LAST);

	// next state; a new strobe rise restarts from any state, except in the load cycle, where load wins and the rise is lost
	// the old word is lost when a rise cuts a readout short
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (cnv_rise) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (load) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				if (cnv_rise) begin
					state_nxt = ST_CONV;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// state, conversion timer, mode latch
	// busy follows the next state so that it rises with the state change
	always @(posedge core_clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			conv_cnt_r <= {`SARSR_CNT_W{1'b0}};
			daisy_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			busy_r <= (state_nxt == ST_CONV);
			if (cnv_rise) begin
				conv_cnt_r <= {`SARSR_CNT_W{1'b0}};
				daisy_r <= ~sdi_s_r;
			end else if (state_r == ST_CONV) begin
				conv_cnt_r <= conv_cnt_r + 1'b1;
			end
		end
	end

	// ==========================================================
	// chip select and output enable
	// strobe low serves 3-wire use, serial input low serves 4-wire use;
	// the idle party keeps its pin high, so one or term covers both
	// hazard: in daisy use sdi carries data, so it must not select there
	assign cs_sel = ~cnv_s_r | ~sdi_s_r;

	// daisy chain drives while the strobe is low and never runs dry;
	// chip-select mode stops after the last result bit
	assign drive = (state_r == ST_READ) &&
		(daisy_r ? ~cnv_s_r : (cs_sel && (bits_left_r != {`SARSR_BITCNT_W{1'b0}})));

	// ==========================================================
	// shift timing
	// a detected fall arms a short wait so the old bit is held first
	// limitation: sync and hold cost several core cycles per fall, so the
	// shift clock must stay far slower than the core clock
	assign shift_go = shift_pend_r && (hold_cnt_r == 2'h0);

	// arm on a fall seen while driving; sdi is taken at that same fall
	always @(posedge core_clk) begin
		if (sys_rst) begin
			shift_pend_r <= 1'b0;
			hold_cnt_r <= 2'h0;
			din_cap_r <= 1'b0;
		end else if (state_r != ST_READ) begin
			shift_pend_r <= 1'b0;
			hold_cnt_r <= 2'h0;
		end else if (sck_fall && drive) begin
			shift_pend_r <= 1'b1;
			hold_cnt_r <= HOLD_CYC - 2'h1;
			din_cap_r <= sdi_s_r;
		end else if (shift_go) begin
			shift_pend_r <= 1'b0;
		end else if (hold_cnt_r != 2'h0) begin
			hold_cnt_r <= hold_cnt_r - 2'h1;
		end
	end

	// ==========================================================
	// result shift register
	// an empty buffer at load sends zeros and flags the underrun
	// msb leaves first; received bits enter at the lsb, so chained devices
	// form one long register
	always @(posedge core_clk) begin
		if (sys_rst) begin
			shreg_r <= {`SARSR_RES_W{1'b0}};
			bits_left_r <= {`SARSR_BITCNT_W{1'b0}};
			underrun_r <= 1'b0;
		end else if (load) begin
			shreg_r <= fifo_valid ? fifo_data : {`SARSR_RES_W{1'b0}};
			bits_left_r <= RES_BITS;
			underrun_r <= ~fifo_valid;
		end else if (shift_go) begin
			shreg_r <= {shreg_r[`SARSR_RES_MSB-1:0], din_cap_r};
			if (bits_left_r != {`SARSR_BITCNT_W{1'b0}}) begin
				bits_left_r <= bits_left_r - 1'b1;
			end
		end
	end

	// ==========================================================
	// output pin
	// idle level is low with the enable high; the pin is then released
	// the pad uses sdo_oe_n as its tristate control
	always @* begin
		sdo_nxt = 1'b0;
		oe_n_nxt = 1'b1;
		if (drive) begin
			sdo_nxt = shreg_r[`SARSR_RES_MSB];
			oe_n_nxt = 1'b0;
		end else begin
			oe_n_nxt = 1'b1;
		end
	end

	// registered so the pin never glitches between bits
	// costs one cycle of latency on every bit and on every release
	always @(posedge core_clk) begin
		if (sys_rst) begin
			sdo_r <= 1'b0;
			oe_n_r <= 1'b1;
		end else begin
			sdo_r <= sdo_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	// ==========================================================
	// port drive
	// every output comes straight from a flop
	assign sdo_o = sdo_r;
	assign sdo_oe_n = oe_n_r;
	assign busy = busy_r;
	assign daisy_mode = daisy_r;
	assign underrun = underrun_r;

endmodule // sarsr_readout

// File: sarsr_readout_monitor.sv
`timescale 1ns/100ps
// ==========
// pin-level checker for the serial readout
module sarsr_readout_monitor (
	// clock and reset
	input logic core_clk,
	input logic sys_rst,
	// link pins
	input logic conversion_strobe,
	input logic sdi,
	input logic sclk,
	input logic sdo_o,
	input logic sdo_oe_n,
	// status
	input logic busy,
	input logic daisy_mode
);
	logic sclk_q;
	logic [7:0] fall_age;
	logic [5:0] nfall;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// age of last shift clock fall, falls seen while driving
	always @(posedge core_clk) begin
		sclk_q <= sclk;
		if (sys_rst) begin
			fall_age <= 8'hff;
			nfall <= 6'h00;
		end else begin
			if (sclk_q && !sclk) fall_age <= 8'h00;
			else if (fall_age != 8'hff) fall_age <= fall_age + 8'h01;
			if (sdo_oe_n) nfall <= 6'h00;
			else if (sclk_q && !sclk) nfall <= nfall + 6'h01;
		end
	end
	a_msb_strobe: assert property (
		!busy && sdi && $fell(conversion_strobe) ##1 !conversion_strobe [*5] |-> !sdo_oe_n)
		else $error("output not enabled by strobe low");
	a_msb_select: assert property (
		!busy && conversion_strobe && $fell(sdi) ##1 !sdi [*5] |-> !sdo_oe_n)
		else $error("output not enabled by select low");
	a_rel_select: assert property (
		($rose(conversion_strobe) && sdi) || ($rose(sdi) && conversion_strobe)
		|-> ##[1:6] sdo_oe_n) else $error("output not released on deselect");
	a_mode_cs: assert property (
		$rose(conversion_strobe) && sdi |-> ##6 !daisy_mode) else $error("mode not select");
	a_mode_daisy: assert property (
		$rose(conversion_strobe) && !sdi |-> ##6 daisy_mode) else $error("mode not daisy");
	a_busy_start: assert property (
		$rose(conversion_strobe) |-> ##6 busy) else $error("conversion not started");
	a_bit_timing: assert property (
		!sdo_oe_n && $past(sdo_oe_n) == 1'b0 && $changed(sdo_o) |-> fall_age inside {[2:7]})
		else $error("data changed away from shift clock fall");
	a_rel_last: assert property (
		nfall == 6'd18 && !daisy_mode |-> ##[1:10] sdo_oe_n) else $error("not released");
	a_chain_on: assert property (
		daisy_mode && nfall == 6'd20 |-> !sdo_oe_n) else $error("chain stopped driving");
endmodule // sarsr_readout_monitor

bind sarsr_readout sarsr_readout_monitor i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
	.conversion_strobe(conversion_strobe), .sdi(sdi), .sclk(sclk), .sdo_o(sdo_o),
	.sdo_oe_n(sdo_oe_n), .busy(busy), .daisy_mode(daisy_mode));

// File: sarsr_host_model.sv
`timescale 1ns/100ps
// ==========
// host: strobe, select and shift clock
module sarsr_host_model (
	// clock
	input logic core_clk,
	// pins driven by the host
	output logic conversion_strobe,
	output logic sdi,
	output logic sclk,
	// pins seen by the host
	input logic sdo_o,
	input logic sdo_oe_n,
	input logic busy
);
	logic flip = 1'b0;
	int timeouts;
	// released line reads as a moving pattern, never the last bit
	always @(posedge core_clk) flip <= ~flip;
	initial begin
		timeouts = 0;
		conversion_strobe = 1'b1;
		sdi = 1'b1;
		sclk = 1'b0;
	end
	// bounded wait for busy
	task automatic wait_busy(input logic lvl);
		for (int k = 0; k < 400 && busy !== lvl; k++) @(posedge core_clk);
		if (busy !== lvl) timeouts++;
	endtask
	// start conversion; mode 0 strobe select, 1 sdi select, 2 daisy
	task automatic convert(input int mode);
		conversion_strobe <= 1'b0;
		sclk <= 1'b0;
		sdi <= (mode != 2);
		repeat (5) @(posedge core_clk);
		conversion_strobe <= 1'b1;
		repeat (6) @(posedge core_clk);
		sdi <= 1'b1;
		wait_busy(1'b1);
		wait_busy(1'b0);
	endtask
	// read n bits, sampled just before each fall
	task automatic frame(input int mode, input int n, input logic [17:0] din,
		output logic [35:0] got);
		got = '0;
		if (mode == 1) sdi <= 1'b0;
		else conversion_strobe <= 1'b0;
		repeat (8) @(posedge core_clk);
		for (int j = 0; j < n; j++) begin
			sclk <= 1'b1;
			if (mode == 2 && j < 18) sdi <= din[17-j];
			repeat (16) @(posedge core_clk);
			got = {got[34:0], sdo_oe_n ? flip : sdo_o};
			sclk <= 1'b0;
			repeat (16) @(posedge core_clk);
		end
	endtask
	// drop the sdi select
	task automatic deselect();
		sdi <= 1'b1;
	endtask
endmodule // sarsr_host_model

// File: sar_adc_serial_readout_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
// ==========
// bench top
module sar_adc_serial_readout_tb;
	logic core_clk, sys_rst, res_valid;
	logic [17:0] res_data;
	wire conversion_strobe, sdi, sclk, sdo_o, sdo_oe_n, res_ready, busy, daisy_mode, underrun;
	int num_errors, checked;
	logic [17:0] ref_q[$];
	sarsr_readout i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.conversion_strobe(conversion_strobe), .sdi(sdi), .sclk(sclk), .sdo_o(sdo_o),
		.sdo_oe_n(sdo_oe_n), .res_valid(res_valid), .res_data(res_data),
		.res_ready(res_ready), .busy(busy), .daisy_mode(daisy_mode), .underrun(underrun));
	sarsr_host_model i_host (.core_clk(core_clk), .conversion_strobe(conversion_strobe),
		.sdi(sdi), .sclk(sclk), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .busy(busy));
	// 200 MHz
	always #2.5 core_clk = ~core_clk;
	// verdict, also reached by timeouts
	task automatic end_of_test();
		num_errors += i_host.timeouts;
		$display("checked %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		logic [17:0] din;
		logic [17:0] exp_w;
		logic [35:0] got;
		logic exp_ur;
		int i, n, mode;
		core_clk = 1'b0;
		sys_rst = 1'b1;
		res_valid = 1'b0;
		res_data = 18'h00000;
		num_errors = 0;
		checked = 0;
		void'($urandom(12169));
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		// fill the buffer until it refuses; a refused word is held
		res_valid <= 1'b1;
		res_data <= 18'($urandom);
		for (i = 0; i < 10; i++) begin
			@(posedge core_clk);
			if (res_ready === 1'b1) begin
				ref_q.push_back(res_data);
				res_data <= 18'($urandom);
			end
		end
		res_valid <= 1'b0;
		`CHK("words stored", 4, ref_q.size())
		`CHK("ready when full", 1'b0, res_ready)
		$display("test fill done");
		// all modes, one aborted read, then drained buffer gives zeros
		for (i = 0; i < 7; i++) begin
			mode = i % 3;
			n = (mode == 2) ? 36 : ((i == 3) ? 7 : 18);
			din = 18'($urandom);
			exp_ur = (ref_q.size() == 0);
			exp_w = exp_ur ? 18'h00000 : ref_q.pop_front();
			i_host.convert(mode);
			if (i_host.timeouts != 0) break;
			`CHK("mode", mode == 2, daisy_mode)
			`CHK("underrun", exp_ur, underrun)
			`CHK("idle before read", 1'b1, sdo_oe_n)
			i_host.frame(mode, n, din, got);
			if (mode == 2) `CHK("chain bits", {exp_w, din}, got)
			else `CHK("result bits", 36'(exp_w >> (18 - n)), got)
			i_host.deselect();
			repeat (10) @(posedge core_clk);
			`CHK("enable after frame", n == 18, sdo_oe_n)
			$display("test %0d mode %0d done", i, mode);
		end
		end_of_test();
	end
endmodule // sar_adc_serial_readout_tb
